/* src/attribute_palette_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - One shared port address loads index or data, chosen by a toggle.
// - Data-read port returns the currently indexed register.
// - Each shared-port write flips the toggle; host writes index, then data.
// - Reading input status one at the mono or colour address chosen by misc_colour_emul resets the toggle.
// - Reading the data-read port leaves the toggle alone.
// - Index bits 4:0 select register 00h-14h; bits 7:6 read zero.
// - Video enable clear forces colour index zero; timing continues.
// - Palette entries reachable by host only while video enable is clear.
// - Sixteen six-bit palette entries form low colour bits; top bits read zero.
// - Outside mode bit 6 pairing, colour index bits 7:6 come from colour select bits 3:2.
// - Outside mode bit 6 pairing, mode bit 7 takes colour bits 5:4 from colour select 1:0.
// - Mode bit 6 pairs two nibbles into one byte every second dot.
// - Mode bit 5 limits panning to the upper split-screen region.
// - Mode bit 3 selects blinking or background intensity from attribute bit 7.
// - Mode bit 2 copies eighth pixel into ninth for codes B0h-DFh.
// - Mode bit 1 interprets text attributes for a monochrome display.
// - Mode bit 0 selects graphics or text; software keeps it consistent.
module attribute_palette_port (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] io_addr,
   input  wire logic        io_rd,
   input  wire logic        io_wr,
   input  wire logic  [7:0] io_wdata,
   input  wire logic        misc_colour_emul,
   input  wire logic        pix_valid,
   input  wire logic  [3:0] pix_nibble,
   input  wire logic  [7:0] text_attr,
   input  wire logic  [7:0] text_code,
   input  wire logic        text_fg,
   input  wire logic        text_ninth,
   input  wire logic        blink_phase,
   input  wire logic        lower_region,
   output logic       [7:0] io_rdata,
   output logic             io_rdata_valid,
   output logic       [7:0] colour_index,
   output logic             colour_valid,
   output logic       [3:0] pan_shift
);
   // ****************************************
   // State
   // ****************************************
   attr_pkg::toggle_t toggle;
   attr_pkg::toggle_t next_toggle;
   logic       [4:0] index_sel;
   logic             video_en;
   logic [15:0][5:0] pal;
   logic       [7:0] mode;
   logic       [3:0] pixel_panning;
   logic       [3:0] colour_select;
   logic             last_fg;
   logic             pair_half;
   logic       [3:0] pair_hi;

   // ****************************************
   // Port decode
   // ****************************************
   wire [15:0] status_addr = misc_colour_emul ? attr_pkg::ADDR_STATUS_COL
                                              : attr_pkg::ADDR_STATUS_MON;
   wire sel_shared  = (io_addr == attr_pkg::ADDR_SHARED);
   wire sel_read    = (io_addr == attr_pkg::ADDR_DATA_RD);
   wire status_rd   = io_rd && (io_addr == status_addr);
   wire shared_wr   = io_wr && sel_shared;
   wire wr_index    = shared_wr && (toggle == attr_pkg::TGL_INDEX);
   wire wr_data     = shared_wr && (toggle == attr_pkg::TGL_DATA);
   wire pal_open    = !video_en;
   wire idx_is_pal  = (index_sel <= attr_pkg::IDX_PAL_LAST);
   wire wr_mode     = wr_data && (index_sel == attr_pkg::IDX_MODE);
   wire wr_pan      = wr_data && (index_sel == attr_pkg::IDX_PANNING);
   wire wr_colour   = wr_data && (index_sel == attr_pkg::IDX_COLOUR);
   wire [5:0] index_word = {video_en, index_sel};

   always_comb begin
      next_toggle = toggle;
      if (status_rd) begin
         next_toggle = attr_pkg::TGL_INDEX;
      end else if (shared_wr) begin
         next_toggle = (toggle == attr_pkg::TGL_INDEX) ? attr_pkg::TGL_DATA
                                                       : attr_pkg::TGL_INDEX;
      end
   end

   // ****************************************
   // Read data selection
   // ****************************************
   logic [7:0] indexed_value;
   always_comb begin
      indexed_value = 8'h00;
      if (idx_is_pal) begin
         // Locked palette answers zero rather than stale data
         indexed_value = pal_open ? {2'h0, pal[index_sel[3:0]]} : 8'h00;
      end else if (index_sel == attr_pkg::IDX_MODE) begin
         indexed_value = mode;
      end else if (index_sel == attr_pkg::IDX_PANNING) begin
         indexed_value = {4'h0, pixel_panning};
      end else if (index_sel == attr_pkg::IDX_COLOUR) begin
         indexed_value = {4'h0, colour_select};
      end
   end
   wire [7:0] rd_value = sel_shared ? {2'h0, index_word} : indexed_value;
   wire       rd_hit   = io_rd && (sel_shared || sel_read);

   // ****************************************
   // Register file
   // ****************************************
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         toggle <= attr_pkg::TGL_INDEX;
      end else begin
         toggle <= next_toggle;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         {video_en, index_sel} <= attr_pkg::RST_INDEX;
      end else if (wr_index) begin
         {video_en, index_sel} <= io_wdata[attr_pkg::VIDEO_EN_BIT:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < attr_pkg::PAL_ENTRIES; g++) begin : g_pal
         wire hit = wr_data && pal_open && idx_is_pal && (index_sel[3:0] == 4'(g));
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               pal[g] <= attr_pkg::RST_PAL;
            end else if (hit) begin
               pal[g] <= io_wdata[5:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode          <= attr_pkg::RST_MODE;
         pixel_panning <= attr_pkg::RST_PAN;
         colour_select <= attr_pkg::RST_COLOUR;
      end else begin
         if (wr_mode) begin
            mode <= io_wdata & attr_pkg::MODE_WMASK;
         end
         if (wr_pan) begin
            pixel_panning <= io_wdata[3:0];
         end
         if (wr_colour) begin
            colour_select <= io_wdata[3:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         io_rdata       <= 8'h00;
         io_rdata_valid <= 1'b0;
      end else begin
         io_rdata       <= rd_hit ? rd_value : io_rdata;
         io_rdata_valid <= rd_hit;
      end
   end

   // ****************************************
   // Pixel path
   // ****************************************
   logic [3:0] nibble;
   logic [7:0] translated;

   text_attr_decode u_text (
      .mode        (mode),
      .pix_nibble  (pix_nibble),
      .text_attr   (text_attr),
      .text_code   (text_code),
      .text_fg     (text_fg),
      .text_ninth  (text_ninth),
      .last_fg     (last_fg),
      .blink_phase (blink_phase),
      .nibble      (nibble)
   );

   palette_translate u_pal (
      .pal          (pal),
      .nibble       (nibble),
      .colour_sel   (colour_select),
      .p54_from_sel (mode[attr_pkg::MODE_P54_BIT]),
      .colour       (translated)
   );

   wire wide     = mode[attr_pkg::MODE_WIDE_BIT];
   wire pair_out = pix_valid && wide && pair_half;
   wire narrow   = pix_valid && !wide;
   // Blanking still emits a pixel per dot, or per nibble pair under mode bit 6, so timing is untouched
   wire [7:0] narrow_val = video_en ? translated : 8'h00;
   wire [7:0] wide_val   = video_en ? {pair_hi, pix_nibble} : 8'h00;
   wire [3:0] next_pan   = (mode[attr_pkg::MODE_PAN_BIT] && lower_region) ? 4'h0
                                                                          : pixel_panning;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         last_fg      <= 1'b0;
         pair_half    <= 1'b0;
         pair_hi      <= 4'h0;
         colour_index <= 8'h00;
         colour_valid <= 1'b0;
         pan_shift    <= 4'h0;
      end else begin
         if (pix_valid && !text_ninth) begin
            last_fg <= text_fg;
         end
         if (pix_valid && wide && !pair_half) begin
            pair_hi <= pix_nibble;
         end
         pair_half    <= (pix_valid && wide) ? !pair_half : (wide && pair_half);
         colour_valid <= narrow || pair_out;
         colour_index <= narrow ? narrow_val : (pair_out ? wide_val : colour_index);
         pan_shift    <= next_pan;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_status_clears: assert property (status_rd |=> toggle == attr_pkg::TGL_INDEX)
      else $error("status read did not reset toggle");
   a_write_flips: assert property (shared_wr && !status_rd |=> toggle != $past(toggle))
      else $error("shared write did not flip toggle");
   a_read_keeps: assert property (io_rd && sel_read && !io_wr |=> $stable(toggle))
      else $error("data read changed toggle");
   a_index_loads: assert property (wr_index ##1 !wr_index [*2]
                                   |-> index_sel == $past(io_wdata[4:0], 2))
      else $error("index not loaded");
   a_read_answer: assert property (io_rd && sel_read
                                   |=> io_rdata_valid && io_rdata == $past(indexed_value))
      else $error("data read answer wrong");
   a_index_topzero: assert property (io_rd && sel_shared |=> io_rdata[7:6] == 2'h0)
      else $error("index reserved bits not zero");
   a_palette_lock: assert property (wr_data && video_en |=> $stable(pal))
      else $error("locked palette was written");
   a_blank_video: assert property (narrow && !video_en |=> colour_valid && colour_index == 8'h00)
      else $error("disabled video not blank");
   a_top_bits: assert property (narrow && video_en |=> colour_index[7:6] == $past(colour_select[3:2]))
      else $error("top colour bits wrong");
   a_pair_rate: assert property (pix_valid && wide && !pair_half |=> !colour_valid ##0 pair_half)
      else $error("wide mode emitted on first nibble");
   a_pan_lower: assert property (mode[attr_pkg::MODE_PAN_BIT] && lower_region |=> pan_shift == 4'h0)
      else $error("lower region panned");

   a_pal_topzero: assert property (io_rd && sel_read && idx_is_pal |=> io_rdata[7:6] == 2'h0)
      else $error("palette reserved bits not zero");
   a_p54_select: assert property (narrow && video_en && mode[attr_pkg::MODE_P54_BIT]
                                  |=> colour_index[5:4] == $past(colour_select[1:0]))
      else $error("colour bits 5:4 not from colour select");

   // ****************************************
   // Text and graphics decode checks
   // ****************************************
   // Nibble is combinational, so these compare in the same cycle
   wire m_gfx   = mode[attr_pkg::MODE_GFX_BIT];
   wire m_mono  = mode[attr_pkg::MODE_MONO_BIT];
   wire m_blink = mode[attr_pkg::MODE_BLINK_BIT];
   wire m_line  = mode[attr_pkg::MODE_LINE_BIT];

   a_gfx_pass: assert property (pix_valid && m_gfx && !(m_blink && blink_phase)
                                |-> nibble == pix_nibble)
      else $error("graphics nibble altered");
   a_blink_bg: assert property (pix_valid && !m_gfx && !m_mono && m_blink && text_attr[7]
                                && blink_phase |-> nibble == {1'b0, text_attr[6:4]})
      else $error("blink phase did not show background");
   a_ninth_bg: assert property (pix_valid && !m_gfx && !m_mono && !m_line && !m_blink
                                && text_ninth |-> nibble == text_attr[7:4])
      else $error("ninth column not background");
   a_mono_fg: assert property (pix_valid && !m_gfx && m_mono && text_fg && !text_ninth
                               && !m_blink
                               |-> nibble[2:0] == ((text_attr[2:0] != 3'h0) ? 3'h7
                                                                             : 3'h0))
      else $error("monochrome foreground wrong");

   c_text_blink: cover property (pix_valid && !m_gfx && m_blink && blink_phase);
   c_index_data: cover property (wr_index ##[1:4] wr_data);
   c_wide_pair: cover property (pair_out);
   c_status_reset: cover property (toggle == attr_pkg::TGL_DATA ##1 status_rd);
endmodule // attribute_palette_port

/* src/attr_pkg.sv */
package attr_pkg;

   // ****************************************
   // Port addresses
   // ****************************************
   localparam logic [15:0] ADDR_SHARED     = 16'h03c0;
   localparam logic [15:0] ADDR_DATA_RD    = 16'h03c1;
   localparam logic [15:0] ADDR_STATUS_MON = 16'h03ba;
   localparam logic [15:0] ADDR_STATUS_COL = 16'h03da;

   // ****************************************
   // Register indices and fields
   // ****************************************
   localparam logic [4:0] IDX_PAL_LAST  = 5'h0f;
   localparam logic [4:0] IDX_MODE      = 5'h10;
   localparam logic [4:0] IDX_PANNING   = 5'h13;
   localparam logic [4:0] IDX_COLOUR    = 5'h14;
   localparam int         PAL_ENTRIES   = 16;
   localparam int         VIDEO_EN_BIT  = 5;
   localparam int         MODE_P54_BIT  = 7;
   localparam int         MODE_WIDE_BIT = 6;
   localparam int         MODE_PAN_BIT  = 5;
   localparam int         MODE_BLINK_BIT = 3;
   localparam int         MODE_LINE_BIT = 2;
   localparam int         MODE_MONO_BIT = 1;
   localparam int         MODE_GFX_BIT  = 0;
   localparam logic [7:0] MODE_WMASK    = 8'hef;
   localparam logic [7:0] LINE_CODE_LO  = 8'hb0;
   localparam logic [7:0] LINE_CODE_HI  = 8'hdf;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [5:0] RST_INDEX  = 6'h00;
   localparam logic [5:0] RST_PAL    = 6'h00;
   localparam logic [7:0] RST_MODE   = 8'h00;
   localparam logic [3:0] RST_PAN    = 4'h0;
   localparam logic [3:0] RST_COLOUR = 4'h0;

   typedef enum logic [1:0] {
      TGL_INDEX = 2'b01,
      TGL_DATA  = 2'b10
   } toggle_t;

endpackage

/* src/text_attr_decode.sv */
`timescale 1ns/1ps
module text_attr_decode (
   input  wire logic [7:0] mode,
   input  wire logic [3:0] pix_nibble,
   input  wire logic [7:0] text_attr,
   input  wire logic [7:0] text_code,
   input  wire logic       text_fg,
   input  wire logic       text_ninth,
   input  wire logic       last_fg,
   input  wire logic       blink_phase,
   output logic      [3:0] nibble
);
   wire       gfx      = mode[attr_pkg::MODE_GFX_BIT];
   wire       blink_en = mode[attr_pkg::MODE_BLINK_BIT];
   wire       mono     = mode[attr_pkg::MODE_MONO_BIT];
   wire       line_chr = (text_code >= attr_pkg::LINE_CODE_LO)
                       && (text_code <= attr_pkg::LINE_CODE_HI);
   // Ninth column copies the eighth only for line-drawing codes
   wire       fg_eff   = text_ninth ? (mode[attr_pkg::MODE_LINE_BIT] && line_chr && last_fg)
                                    : text_fg;
   // Attribute bit 7 is either blink or background intensity
   wire       blink_hit = blink_en && text_attr[7] && blink_phase;
   wire [3:0] bg_col   = {blink_en ? 1'b0 : text_attr[7], text_attr[6:4]};
   wire [3:0] fg_col   = text_attr[3:0];
   wire [3:0] bg_mono  = (text_attr[6:4] != 3'h0) ? {bg_col[3], 3'h7} : 4'h0;
   wire [3:0] fg_mono  = (fg_col[2:0] != 3'h0) ? {fg_col[3], 3'h7} : 4'h0;
   wire [3:0] fg_sel   = mono ? fg_mono : fg_col;
   wire [3:0] bg_sel   = mono ? bg_mono : bg_col;
   wire [3:0] text_nib = (fg_eff && !blink_hit) ? fg_sel : bg_sel;
   // Graphics blinking clears the intensity plane during the blink phase
   wire [3:0] gfx_nib  = {pix_nibble[3] & ~(blink_en & blink_phase), pix_nibble[2:0]};

   assign nibble = gfx ? gfx_nib : text_nib;
endmodule // text_attr_decode

/* src/palette_translate.sv */
`timescale 1ns/1ps
module palette_translate (
   input  wire logic [15:0][5:0] pal,
   input  wire logic       [3:0] nibble,
   input  wire logic       [3:0] colour_sel,
   input  wire logic             p54_from_sel,
   output logic            [7:0] colour
);
   wire [5:0] entry = pal[nibble];
   wire [1:0] p54   = p54_from_sel ? colour_sel[1:0] : entry[5:4];

   assign colour = {colour_sel[3:2], p54, entry[3:0]};
endmodule // palette_translate

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        mclk;
   logic        sys_rst;
   logic [15:0] io_addr;
   logic        io_rd;
   logic        io_wr;
   logic  [7:0] io_wdata;
   logic        misc_colour_emul;
   logic        pix_valid;
   logic  [3:0] pix_nibble;
   logic        lower_region;
   logic  [7:0] text_attr;
   logic  [7:0] text_code;
   logic        text_fg;
   logic        text_ninth;
   logic        blink_phase;
   logic  [7:0] io_rdata;
   logic        io_rdata_valid;
   logic  [7:0] colour_index;
   logic        colour_valid;
   logic  [3:0] pan_shift;
   int          failures;
   int          samples_checked;

   attribute_palette_port uut (
      .mclk             (mclk),
      .sys_rst          (sys_rst),
      .io_addr          (io_addr),
      .io_rd            (io_rd),
      .io_wr            (io_wr),
      .io_wdata         (io_wdata),
      .misc_colour_emul (misc_colour_emul),
      .pix_valid        (pix_valid),
      .pix_nibble       (pix_nibble),
      .text_attr        (text_attr),
      .text_code        (text_code),
      .text_fg          (text_fg),
      .text_ninth       (text_ninth),
      .blink_phase      (blink_phase),
      .lower_region     (lower_region),
      .io_rdata         (io_rdata),
      .io_rdata_valid   (io_rdata_valid),
      .colour_index     (colour_index),
      .colour_valid     (colour_valid),
      .pan_shift        (pan_shift)
   );

   // ****************************************
   // Bus and pixel helpers
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge mclk);
      #1;
      io_wr = 1'b0;
   endtask

   // Status reads get no answer from this block, so answered is 0 there
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic answered);
      @(posedge mclk);
      #1;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge mclk);
      #1;
      io_rd = 1'b0;
      if (answered) begin
         chk({7'h00, io_rdata_valid}, 8'h01);
         chk(io_rdata, exp);
      end
   endtask

   // Status read first, so the toggle state never matters
   task automatic setreg(input logic [7:0] idx, input logic [7:0] d);
      rd(misc_colour_emul ? attr_pkg::ADDR_STATUS_COL : attr_pkg::ADDR_STATUS_MON, 8'h00, 1'b0);
      wr(attr_pkg::ADDR_SHARED, idx);
      wr(attr_pkg::ADDR_SHARED, d);
   endtask

   task automatic pix(input logic [3:0] n, input logic ev, input logic [7:0] exp);
      @(posedge mclk);
      #1;
      pix_nibble = n;
      pix_valid = 1'b1;
      @(posedge mclk);
      #1;
      pix_valid = 1'b0;
      chk({7'h00, colour_valid}, {7'h00, ev});
      if (ev) begin
         chk(colour_index, exp);
      end
   endtask

   task automatic pan_chk(input logic lr, input logic [3:0] exp);
      lower_region = lr;
      repeat (2) @(posedge mclk);
      #1;
      chk({4'h0, pan_shift}, {4'h0, exp});
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_toggle;
      wr(attr_pkg::ADDR_SHARED, 8'h10);
      wr(attr_pkg::ADDR_SHARED, 8'hff);
      rd(attr_pkg::ADDR_DATA_RD, 8'hef, 1'b1);
      rd(attr_pkg::ADDR_SHARED, 8'h10, 1'b1);
   endtask

   task automatic t_keep;
      wr(attr_pkg::ADDR_SHARED, 8'h10);
      rd(attr_pkg::ADDR_DATA_RD, 8'hef, 1'b1);
      rd(attr_pkg::ADDR_DATA_RD, 8'hef, 1'b1);
      wr(attr_pkg::ADDR_SHARED, 8'h03);
      rd(attr_pkg::ADDR_DATA_RD, 8'h03, 1'b1);
   endtask

   // Matching status address resets the toggle, the other one must not
   task automatic t_status;
      for (int e = 0; e < 2; e++) begin
         misc_colour_emul = e[0];
         wr(attr_pkg::ADDR_SHARED, 8'h10);
         rd(e ? attr_pkg::ADDR_STATUS_COL : attr_pkg::ADDR_STATUS_MON, 8'h00, 1'b0);
         wr(attr_pkg::ADDR_SHARED, 8'h14);
         rd(attr_pkg::ADDR_SHARED, 8'h14, 1'b1);
         wr(attr_pkg::ADDR_SHARED, 8'h00);
         wr(attr_pkg::ADDR_SHARED, 8'h10);
         rd(e ? attr_pkg::ADDR_STATUS_MON : attr_pkg::ADDR_STATUS_COL, 8'h00, 1'b0);
         wr(attr_pkg::ADDR_SHARED, 8'h02);
         rd(attr_pkg::ADDR_DATA_RD, 8'h02, 1'b1);
      end
   endtask

   task automatic t_lock;
      setreg(8'h03, 8'hff);
      rd(attr_pkg::ADDR_DATA_RD, 8'h3f, 1'b1);
      wr(attr_pkg::ADDR_SHARED, 8'h23);
      wr(attr_pkg::ADDR_SHARED, 8'h00);
      rd(attr_pkg::ADDR_DATA_RD, 8'h00, 1'b1);
      wr(attr_pkg::ADDR_SHARED, 8'hc3);
      rd(attr_pkg::ADDR_SHARED, 8'h03, 1'b1);
      rd(attr_pkg::ADDR_DATA_RD, 8'h3f, 1'b1);
   endtask

   task automatic t_pixel;
      setreg(8'h03, 8'h15);
      setreg(8'h14, 8'h0c);
      setreg(8'h30, 8'h01);
      pix(4'h3, 1'b1, 8'hd5);
      setreg(8'h30, 8'h81);
      pix(4'h3, 1'b1, 8'hc5);
      setreg(8'h10, 8'h01);
      pix(4'h3, 1'b1, 8'h00);
   endtask

   task automatic t_wide;
      setreg(8'h30, 8'h41);
      pix(4'h3, 1'b0, 8'h00);
      pix(4'ha, 1'b1, 8'h3a);
      setreg(8'h30, 8'h01);
   endtask

   // Palette: entry 3 = 15h, others 00h; colour select 0Ch
   task automatic t_text;
      setreg(8'h30, 8'h00);
      text_attr = 8'h93;
      text_code = 8'hc4;
      text_fg = 1'b1;
      text_ninth = 1'b0;
      blink_phase = 1'b0;
      pix(4'h0, 1'b1, 8'hd5);
      text_fg = 1'b0;
      pix(4'h0, 1'b1, 8'hc0);
      setreg(8'h30, 8'h08);
      text_fg = 1'b1;
      blink_phase = 1'b1;
      pix(4'h0, 1'b1, 8'hc0);
      blink_phase = 1'b0;
      setreg(8'h30, 8'h04);
      text_ninth = 1'b1;
      pix(4'h0, 1'b1, 8'hd5);
      text_code = 8'h41;
      pix(4'h0, 1'b1, 8'hc0);
      text_ninth = 1'b0;
      setreg(8'h30, 8'h02);
      pix(4'h0, 1'b1, 8'hc0);
      setreg(8'h30, 8'h01);
   endtask

   task automatic t_pan;
      setreg(8'h33, 8'h05);
      pan_chk(1'b1, 4'h5);
      setreg(8'h30, 8'h21);
      pan_chk(1'b1, 4'h0);
      pan_chk(1'b0, 4'h5);
   endtask

   task automatic tally_and_finish;
      if (failures == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ****************************************
   // Clock, watchdog and main sequence
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #20000;
      failures++;
      tally_and_finish();
   end

   initial begin
      failures = 0;
      samples_checked = 0;
      sys_rst = 1'b1;
      io_addr = 16'h0000;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 8'h00;
      misc_colour_emul = 1'b1;
      pix_valid = 1'b0;
      pix_nibble = 4'h0;
      lower_region = 1'b0;
      text_attr = 8'h00;
      text_code = 8'h00;
      text_fg = 1'b0;
      text_ninth = 1'b0;
      blink_phase = 1'b0;
      repeat (10) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      t_toggle();
      t_keep();
      t_status();
      t_lock();
      t_pixel();
      t_wide();
      t_text();
      t_pan();
      tally_and_finish();
   end
endmodule // tb
